// File: core/config_control_handshake.v
// Purpose: Configuration control sequencer: power-up reset, configuration,
//          initialization, user mode and error, driven by the wired handshake lines.
// Assumes: All pins are asynchronous to clock and pass two flops before use.
// Notes: Data loading itself is outside; software reports completion or error
//        through the control register.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "cfg_ctrl_defines.vh"

// How it works
// - The two scheme select pins are read as a two-bit code and latched for the next configuration.
// - The I/O level pin is high for 1.8 V banks, low otherwise, and nothing starts before bank power-good.
// - A low reconfiguration request in user mode drops the configuration, resets and floats user I/O.
// - The rising reconfiguration request, or the end of power-up with the request high, starts a new configuration.
// - Right after power-up the status line is pulled low and released within 5 us.
// - An error found while configuring pulls the status line low.
// - A status line sensed low during configuration or initialization, not driven by us, means error.
// - In user mode the status line is ignored entirely.
// - The load-complete line is held low from reset through the whole data transfer.
// - The load-complete line is released only when all data arrived clean, as initialization starts.
// - Initialization runs only once the load-complete line reads high, then user mode follows.
// - In user mode a low load-complete line has no effect.
module config_control_handshake #(
   parameter POR_CYCLES = `CFG_POR_CYCLES,
   parameter INIT_CYCLES = `CFG_INIT_CYCLES
) (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Register port
   input wire [`CFG_ADDR_W-1:0] reg_addr,
   input wire [`CFG_DATA_W-1:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [`CFG_DATA_W-1:0] reg_rdata,
   // Selection pins
   input wire scheme_select_bit0,
   input wire scheme_select_bit1,
   input wire io_level_select,
   input wire bank_power_good,
   input wire reconfig_request_n,
   // Wired status line
   input wire status_line_in,
   output reg status_line_out,
   output reg status_line_oe,
   // Wired load-complete line
   input wire load_complete_in,
   output reg load_complete_out,
   output reg load_complete_oe,
   // Device state
   output reg [1:0] config_scheme,
   output reg io_level_1v8,
   output reg user_io_enable,
   output reg config_busy
);

   // One-hot states, with the reset state all zero
   localparam [6:0] ST_POWER_UP = 7'h01;
   localparam [6:0] ST_WAIT_STATUS = 7'h02;
   localparam [6:0] ST_CONFIG = 7'h04;
   localparam [6:0] ST_INIT_WAIT = 7'h08;
   localparam [6:0] ST_INIT_RUN = 7'h10;
   localparam [6:0] ST_USER = 7'h20;
   localparam [6:0] ST_ERROR = 7'h40;
   localparam [6:0] ST_RESET = 7'h00;

   // Last count values, cut on purpose to the counter widths
   localparam integer POR_LAST_FULL = POR_CYCLES - 1;
   localparam integer INIT_LAST_FULL = INIT_CYCLES - 1;
   localparam [`CFG_POR_CNT_W-1:0] POR_LAST = POR_LAST_FULL[`CFG_POR_CNT_W-1:0];
   localparam [`CFG_INIT_CNT_W-1:0] INIT_LAST = INIT_LAST_FULL[`CFG_INIT_CNT_W-1:0];

   // Address match, shared by the write and the read decode
   function reg_hit;
      input [`CFG_ADDR_W-1:0] addr;
      input [`CFG_ADDR_W-1:0] offset;
      begin
         reg_hit = (addr == offset);
      end
   endfunction

   // Pin synchronisers; reconfiguration request idles released
   wire [`CFG_SYNC_W-1:0] pins_async;
   wire [`CFG_SYNC_W-1:0] pins;

   assign pins_async = {load_complete_in, status_line_in, bank_power_good,
                        io_level_select, scheme_select_bit1, scheme_select_bit0,
                        reconfig_request_n};

   pin_sync #(
      .WIDTH(`CFG_SYNC_W),
      .RESET_VALUE(7'h01)
   ) u_pin_sync (
      .clock(clock),
      .arst_n(arst_n),
      .async_in(pins_async),
      .sync_out(pins)
   );

   wire reconfig_n_s;
   wire [1:0] scheme_s;
   wire io_level_s;
   wire power_good_s;
   wire status_s;
   wire load_s;

   assign reconfig_n_s = pins[`CFG_SYNC_RECONFIG];
   assign scheme_s = {pins[`CFG_SYNC_SEL1], pins[`CFG_SYNC_SEL0]};
   assign io_level_s = pins[`CFG_SYNC_IO_LEVEL];
   assign power_good_s = pins[`CFG_SYNC_POWER_GOOD];
   assign status_s = pins[`CFG_SYNC_STATUS];
   assign load_s = pins[`CFG_SYNC_LOAD];

   // Register write decode
   wire ctrl_write;
   wire data_done_pulse;
   wire data_error_pulse;

   assign ctrl_write = reg_write && reg_hit(reg_addr, `CFG_REG_CTRL);
   assign data_done_pulse = ctrl_write && reg_wdata[`CFG_CTRL_DATA_DONE];
   assign data_error_pulse = ctrl_write && reg_wdata[`CFG_CTRL_DATA_ERROR];

   // Sequencer
   reg [6:0] state;
   reg [6:0] next_state;
   reg [`CFG_POR_CNT_W-1:0] por_count;
   reg [`CFG_INIT_CNT_W-1:0] init_count;
   reg err_external;
   reg err_internal;
   reg next_err_external;
   reg next_err_internal;

   always @* begin
      next_state = state;
      next_err_external = err_external;
      next_err_internal = err_internal;
      case (state)
         ST_POWER_UP: begin
            if (por_count == POR_LAST) begin
               next_state = reconfig_n_s ? ST_WAIT_STATUS : ST_RESET;
            end
         end
         ST_RESET: begin
            // Only the release of the request leaves reset
            if (reconfig_n_s) begin
               next_state = ST_WAIT_STATUS;
            end
         end
         ST_WAIT_STATUS: begin
            // An external holder may keep the line low for a long time
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end else if (status_s && power_good_s) begin
               next_state = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end else if (data_error_pulse) begin
               next_state = ST_ERROR;
               next_err_internal = 1'b1;
            end else if (!status_s) begin
               next_state = ST_ERROR;
               next_err_external = 1'b1;
            end else if (data_done_pulse) begin
               next_state = ST_INIT_WAIT;
            end
         end
         ST_INIT_WAIT: begin
            // Another device on the wire may hold load-complete low
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end else if (!status_s) begin
               next_state = ST_ERROR;
               next_err_external = 1'b1;
            end else if (load_s) begin
               next_state = ST_INIT_RUN;
            end
         end
         ST_INIT_RUN: begin
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end else if (!status_s) begin
               next_state = ST_ERROR;
               next_err_external = 1'b1;
            end else if (init_count == INIT_LAST) begin
               next_state = ST_USER;
            end
         end
         ST_USER: begin
            // Status and load-complete levels are not looked at here
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end
         end
         ST_ERROR: begin
            if (!reconfig_n_s) begin
               next_state = ST_RESET;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
      // A new cycle forgets the cause of the last failure
      if (next_state == ST_RESET) begin
         next_err_external = 1'b0;
         next_err_internal = 1'b0;
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_POWER_UP;
         por_count <= {`CFG_POR_CNT_W{1'b0}};
         init_count <= {`CFG_INIT_CNT_W{1'b0}};
         err_external <= 1'b0;
         err_internal <= 1'b0;
      end else begin
         state <= next_state;
         err_external <= next_err_external;
         err_internal <= next_err_internal;
         if (state == ST_POWER_UP) begin
            por_count <= por_count + 1'b1;
         end
         if (state == ST_INIT_RUN) begin
            init_count <= init_count + 1'b1;
         end else begin
            init_count <= {`CFG_INIT_CNT_W{1'b0}};
         end
      end
   end

   // Pin drive follows the next state so it lines up with the state register
   wire next_pull_status;
   wire next_pull_load;
   wire next_user;
   wire next_busy;

   assign next_pull_status = (next_state == ST_POWER_UP) ||
                             (next_state == ST_RESET) ||
                             (next_state == ST_ERROR);
   assign next_pull_load = (next_state == ST_POWER_UP) ||
                           (next_state == ST_RESET) ||
                           (next_state == ST_WAIT_STATUS) ||
                           (next_state == ST_CONFIG) ||
                           (next_state == ST_ERROR);
   assign next_user = (next_state == ST_USER);
   assign next_busy = (next_state == ST_CONFIG) ||
                      (next_state == ST_INIT_WAIT) ||
                      (next_state == ST_INIT_RUN);

   wire enter_config;

   assign enter_config = (state == ST_WAIT_STATUS) && (next_state == ST_CONFIG);

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status_line_out <= 1'b0;
         status_line_oe <= 1'b1;
         load_complete_out <= 1'b0;
         load_complete_oe <= 1'b1;
         user_io_enable <= 1'b0;
         config_busy <= 1'b0;
         config_scheme <= 2'h0;
         io_level_1v8 <= 1'b0;
      end else begin
         // The drivers only ever pull low; release means enable off
         status_line_out <= 1'b0;
         load_complete_out <= 1'b0;
         status_line_oe <= next_pull_status;
         load_complete_oe <= next_pull_load;
         user_io_enable <= next_user;
         config_busy <= next_busy;
         // Scheme and bank level are taken once, as configuration starts
         if (enter_config) begin
            config_scheme <= scheme_s;
            io_level_1v8 <= io_level_s;
         end
      end
   end

   // Register read, answered in the next cycle; unmapped reads give zero
   reg [`CFG_DATA_W-1:0] next_rdata;

   always @* begin
      next_rdata = {`CFG_DATA_W{1'b0}};
      if (reg_hit(reg_addr, `CFG_REG_STATUS)) begin
         next_rdata[`CFG_ST_STATE_LSB +: `CFG_ST_STATE_W] = state;
         next_rdata[`CFG_ST_STATUS_LINE] = status_s;
         next_rdata[`CFG_ST_LOAD_LINE] = load_s;
         next_rdata[`CFG_ST_POWER_GOOD] = power_good_s;
         next_rdata[`CFG_ST_RECONFIG_N] = reconfig_n_s;
         next_rdata[`CFG_ST_ERR_EXT] = err_external;
         next_rdata[`CFG_ST_ERR_INT] = err_internal;
         next_rdata[`CFG_ST_USER_MODE] = (state == ST_USER);
      end else if (reg_hit(reg_addr, `CFG_REG_SCHEME)) begin
         next_rdata[`CFG_SC_SCHEME_LSB +: 2] = config_scheme;
         next_rdata[`CFG_SC_IO_LEVEL] = io_level_1v8;
         next_rdata[`CFG_SC_LIVE_LSB +: 2] = scheme_s;
         next_rdata[`CFG_SC_LIVE_IO] = io_level_s;
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= {`CFG_DATA_W{1'b0}};
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         // Read data stand for exactly one cycle
         reg_rdata <= {`CFG_DATA_W{1'b0}};
      end
   end

endmodule // config_control_handshake

// File: core/cfg_ctrl_defines.vh
// Purpose: Shared constants for the configuration control sequencer.
// Assumes: Included by bare name; definitions only.
// Notes: Times are kept in their own unit; cycle counts derive from the clock period.
`ifndef CFG_CTRL_DEFINES_VH
`define CFG_CTRL_DEFINES_VH

// Clock
`define CFG_CLK_PERIOD_NS 10

// Power-up status pull-down: longest time, so the count rounds down
`define CFG_POR_RELEASE_NS 5000
`define CFG_POR_CYCLES (`CFG_POR_RELEASE_NS / `CFG_CLK_PERIOD_NS)
`define CFG_POR_CNT_W 9

// Initialization length after the load-complete line reads high
`define CFG_INIT_CYCLES 16
`define CFG_INIT_CNT_W 8

// Register bus
`define CFG_ADDR_W 8
`define CFG_DATA_W 32
`define CFG_REG_CTRL 8'h00
`define CFG_REG_STATUS 8'h04
`define CFG_REG_SCHEME 8'h08

// Control register write bits (self-clearing pulses)
`define CFG_CTRL_DATA_DONE 0
`define CFG_CTRL_DATA_ERROR 1

// Status register fields
`define CFG_ST_STATE_LSB 0
`define CFG_ST_STATE_W 7
`define CFG_ST_STATUS_LINE 8
`define CFG_ST_LOAD_LINE 9
`define CFG_ST_POWER_GOOD 10
`define CFG_ST_RECONFIG_N 11
`define CFG_ST_ERR_EXT 12
`define CFG_ST_ERR_INT 13
`define CFG_ST_USER_MODE 14

// Scheme register fields
`define CFG_SC_SCHEME_LSB 0
`define CFG_SC_IO_LEVEL 2
`define CFG_SC_LIVE_LSB 4
`define CFG_SC_LIVE_IO 6

// Synchroniser layout
`define CFG_SYNC_W 7
`define CFG_SYNC_RECONFIG 0
`define CFG_SYNC_SEL0 1
`define CFG_SYNC_SEL1 2
`define CFG_SYNC_IO_LEVEL 3
`define CFG_SYNC_POWER_GOOD 4
`define CFG_SYNC_STATUS 5
`define CFG_SYNC_LOAD 6

`endif

// File: core/pin_sync.v
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherency is implied.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps

module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Levels
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // pin_sync

// File: tb/cfg_far_side.sv
// Purpose: Far-side model, a configuration memory on the two wired lines.
// Assumes: Both lines have pull-ups, so a released line reads high.
// Notes: The bench commands extra pull-downs to act as a restarting memory.
`timescale 1ns/1ps
module cfg_far_side #(
   parameter HOLD = 20
) (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Device drive
   input wire status_line_out,
   input wire status_line_oe,
   input wire load_complete_out,
   input wire load_complete_oe,
   // Bench commands
   input wire pull_status,
   input wire pull_load,
   // Wired levels
   output wire status_line_in,
   output wire load_complete_in
);
   reg [7:0] held;
   // The memory keeps status low for its own power-up time
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         held <= 8'h00;
      else if (held != HOLD)
         held <= held + 8'h01;
   end
   assign status_line_in = (status_line_oe ? status_line_out : 1'b1) & (held == HOLD)
      & !pull_status;
   assign load_complete_in = (load_complete_oe ? load_complete_out : 1'b1) & !pull_load;
endmodule // cfg_far_side

// File: tb/config_control_handshake_chk.sv
// Purpose: Port-level checks for the configuration sequencer.
// Assumes: Pins are held stable while the sequencer reads them.
// Notes: A pin change shows at the outputs three edges later.
`timescale 1ns/1ps
module config_control_handshake_chk #(
   parameter POR_CYCLES = 4,
   parameter INIT_CYCLES = 2
) (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Pins
   input wire scheme_select_bit0,
   input wire scheme_select_bit1,
   input wire io_level_select,
   input wire bank_power_good,
   input wire reconfig_request_n,
   input wire status_line_in,
   input wire load_complete_in,
   // Outputs
   input wire status_line_out,
   input wire status_line_oe,
   input wire load_complete_out,
   input wire load_complete_oe,
   input wire [1:0] config_scheme,
   input wire io_level_1v8,
   input wire user_io_enable,
   input wire config_busy
);
   reg [15:0] up;
   // Saturating age since reset, to keep the power-up window out of later checks
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         up <= 16'h0000;
      else if (up != 16'hFFFF)
         up <= up + 16'h0001;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_drive_low_only: assert property (!(status_line_oe && status_line_out)
      && !(load_complete_oe && load_complete_out)) else $error("line driven high");
   a_por_pull: assert property (up < POR_CYCLES - 1 |-> status_line_oe)
      else $error("status not pulled at power-up");
   a_por_free: assert property (up == POR_CYCLES + 2 && reconfig_request_n
      |-> !status_line_oe) else $error("status not released");
   a_error_hold: assert property (status_line_oe && up > POR_CYCLES + 4
      && reconfig_request_n && $past(reconfig_request_n) && $past(reconfig_request_n, 2)
      && $past(reconfig_request_n, 3) |=> status_line_oe) else $error("error left");
   a_reconfig_reset: assert property ($fell(reconfig_request_n) && user_io_enable
      |-> ##3 (!user_io_enable && status_line_oe && load_complete_oe))
      else $error("no reset on request");
   a_config_entry: assert property ($rose(config_busy) |-> load_complete_oe
      && !status_line_oe && $past(bank_power_good, 2) && $past(status_line_in, 2))
      else $error("bad config entry");
   a_scheme_latch: assert property ($rose(config_busy) |-> io_level_1v8 == io_level_select
      && config_scheme == {scheme_select_bit1, scheme_select_bit0})
      else $error("scheme not latched");
   a_user_after_load: assert property ($rose(user_io_enable)
      |-> $past(load_complete_in, 3) && $past(config_busy)) else $error("early user mode");
   a_user_keeps: assert property (user_io_enable && reconfig_request_n
      && $past(reconfig_request_n) && $past(reconfig_request_n, 2) |=> user_io_enable)
      else $error("user mode lost");
endmodule // config_control_handshake_chk

// File: tb/config_control_handshake_tb.sv
// Purpose: Self-checking bench for the configuration sequencer.
// Assumes: Short power-up and init counts; far side is cfg_far_side.
// Notes: Read data is compared by a monitor against queued expectations.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module config_control_handshake_tb;
   localparam POR_CYCLES = 4;
   localparam INIT_CYCLES = 2;
   reg clock = 0;
   reg arst_n = 0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h00000000;
   reg reg_write = 0;
   reg reg_read = 0;
   reg s0 = 0, s1 = 0, io = 0, pg = 0, rq = 1, ps = 0, pl = 0, pend = 0;
   wire [31:0] rdata;
   wire st_in, st_out, st_oe, ld_in, ld_out, ld_oe, lv, user, busy;
   wire [1:0] scheme;
   int errors = 0;
   int tests_run = 0;
   reg [31:0] qe[$];
   reg [31:0] qm[$];
   reg [31:0] e, m;
   config_control_handshake #(.POR_CYCLES(POR_CYCLES), .INIT_CYCLES(INIT_CYCLES))
      config_control_handshake_i (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
      .scheme_select_bit0(s0), .scheme_select_bit1(s1), .io_level_select(io),
      .bank_power_good(pg), .reconfig_request_n(rq), .status_line_in(st_in),
      .status_line_out(st_out), .status_line_oe(st_oe), .load_complete_in(ld_in),
      .load_complete_out(ld_out), .load_complete_oe(ld_oe), .config_scheme(scheme),
      .io_level_1v8(lv), .user_io_enable(user), .config_busy(busy));
   cfg_far_side #(.HOLD(20)) cfg_far_side_i (.clock(clock), .arst_n(arst_n),
      .status_line_out(st_out), .status_line_oe(st_oe), .load_complete_out(ld_out),
      .load_complete_oe(ld_oe), .pull_status(ps), .pull_load(pl),
      .status_line_in(st_in), .load_complete_in(ld_in));
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task rd(input [7:0] a, input [31:0] ex, input [31:0] mk);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      qe.push_back(ex);
      qm.push_back(mk);
      @(posedge clock);
      reg_read <= 1'b0;
   endtask
   task wr(input [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= 8'h00;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   function logic pick(input int w);
      pick = (w == 0) ? busy : (w == 1) ? ld_oe : user;
   endfunction
   // Bounded wait so a stuck sequencer fails instead of hanging
   task wt(input int w, input logic v);
      int i;
      @(negedge clock);
      for (i = 0; i < 100 && pick(w) !== v; i++)
         @(negedge clock);
      `CHK("wait", v, pick(w))
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   always @(posedge clock) begin
      if (pend && qe.size() > 0) begin
         e = qe.pop_front();
         m = qm.pop_front();
         `CHK("rdata", e, rdata & m)
      end
      pend <= reg_read;
   end
   initial forever #5 clock = ~clock;
   initial begin
      #100000;
      errors++;
      end_sim;
   end
   initial begin
      void'($urandom(77));
      {s1, s0, io} <= 3'($urandom);
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      `CHK("st_oe", 1'b1, st_oe)
      `CHK("ld_oe", 1'b1, ld_oe)
      cyc(8);
      @(posedge clock);
      pg <= 1'b1;
      cyc(6);
      `CHK("busy", 1'b0, busy)
      `CHK("st_oe", 1'b0, st_oe)
      wt(0, 1'b1);
      `CHK("scheme", {s1, s0}, scheme)
      `CHK("lv", io, lv)
      `CHK("ld_oe", 1'b1, ld_oe)
      rd(8'h08, {29'h0, io, s1, s0}, 32'h00000007);
      $display("T1 done");
      @(posedge clock);
      pl <= 1'b1;
      wr(32'h00000001);
      wt(1, 1'b0);
      cyc(10);
      `CHK("user", 1'b0, user)
      @(posedge clock);
      pl <= 1'b0;
      wt(2, 1'b1);
      `CHK("busy", 1'b0, busy)
      rd(8'h04, 32'h00000020, 32'h0000007F);
      $display("T2 done");
      @(posedge clock);
      ps <= 1'b1;
      pl <= 1'b1;
      cyc(10);
      `CHK("user", 1'b1, user)
      @(posedge clock);
      ps <= 1'b0;
      pl <= 1'b0;
      {s1, s0, io} <= 3'($urandom);
      pg <= 1'b0;
      cyc(3);
      @(posedge clock);
      rq <= 1'b0;
      cyc(5);
      `CHK("user", 1'b0, user)
      `CHK("lines", 2'b11, {st_oe, ld_oe})
      rd(8'h04, 32'h00000000, 32'h0000007F);
      @(posedge clock);
      rq <= 1'b1;
      cyc(20);
      `CHK("busy", 1'b0, busy)
      @(posedge clock);
      pg <= 1'b1;
      wt(0, 1'b1);
      `CHK("scheme", {io, s1, s0}, {lv, scheme})
      $display("T3 done");
      @(posedge clock);
      ps <= 1'b1;
      cyc(3);
      @(posedge clock);
      ps <= 1'b0;
      cyc(5);
      `CHK("busy", 1'b0, busy)
      cyc(10);
      `CHK("st_oe", 1'b1, st_oe)
      rd(8'h04, 32'h00001040, 32'h0000307F);
      rd(8'h10, 32'h00000000, 32'hFFFFFFFF);
      $display("T4 done");
      @(posedge clock);
      rq <= 1'b0;
      cyc(5);
      @(posedge clock);
      rq <= 1'b1;
      wt(0, 1'b1);
      wr(32'h00000002);
      cyc(5);
      `CHK("busy", 1'b0, busy)
      `CHK("st_oe", 1'b1, st_oe)
      rd(8'h04, 32'h00002040, 32'h0000207F);
      $display("T5 done");
      cyc(3);
      end_sim;
   end
endmodule // config_control_handshake_tb
bind config_control_handshake config_control_handshake_chk #(.POR_CYCLES(POR_CYCLES),
   .INIT_CYCLES(INIT_CYCLES)) chk_i (.clock(clock), .arst_n(arst_n),
   .scheme_select_bit0(scheme_select_bit0), .scheme_select_bit1(scheme_select_bit1),
   .io_level_select(io_level_select), .bank_power_good(bank_power_good),
   .reconfig_request_n(reconfig_request_n), .status_line_in(status_line_in),
   .load_complete_in(load_complete_in), .status_line_out(status_line_out),
   .status_line_oe(status_line_oe), .load_complete_out(load_complete_out),
   .load_complete_oe(load_complete_oe), .config_scheme(config_scheme),
   .io_level_1v8(io_level_1v8), .user_io_enable(user_io_enable), .config_busy(config_busy));
